// ### dmc_cfg.svh
/*
 Constants of the display mode configuration block: register indices and
 addresses, field positions, masks, reset values and code points.
 Assumes it is included by its bare name after the package is compiled.
*/
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH

`define DMC_IDX_DEPTH 12'h0832
`define DMC_IDX_DBUF 12'h0834
`define DMC_ADDR_DEPTH {2'b00, `DMC_IDX_DEPTH, 2'b00}
`define DMC_ADDR_DBUF {2'b00, `DMC_IDX_DBUF, 2'b00}
`define DMC_DEPTH_MASK 16'h8f77
`define DMC_DBUF_MASK 16'hff07
`define DMC_DEPTH_RESET 16'h0000
`define DMC_DBUF_RESET 16'h0000

`define DMC_DB_EN_BIT 15
`define DMC_DB_WIN_MSB 14
`define DMC_DB_WIN_LSB 13
`define DMC_DB_SRC_MSB 12
`define DMC_DB_SRC_LSB 11
`define DMC_MAIN_MSB 2
`define DMC_MAIN_LSB 0

`define DMC_PANEL_MONO 3'h0
`define DMC_PANEL_TYPE2 3'h2
`define DMC_OUT_YUV 3'h4

`define DMC_BPP_NONE 6'h00
`define DMC_BPP_8 6'h08
`define DMC_BPP_16 6'h10
`define DMC_BPP_32 6'h20

`define DMC_COLOURS_NONE 25'h000_0000
`define DMC_COLOURS_GREY 25'h000_0040
`define DMC_COLOURS_8 25'h000_0100
`define DMC_COLOURS_16 25'h001_0000
`define DMC_COLOURS_18 25'h004_0000
`define DMC_COLOURS_24 25'h100_0000

`endif

// ### dmc_pkg.sv
/*
 Types of the display mode configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dmc_pkg;

   typedef enum logic [2:0] {
      DMC_DEPTH_8 = 3'h0,
      DMC_DEPTH_16 = 3'h1,
      DMC_DEPTH_YUV = 3'h2,
      DMC_DEPTH_32 = 3'h3
   } dmc_depth_t;

   typedef enum logic [1:0] {
      DMC_WIN_MAIN = 2'h0,
      DMC_WIN_OVL_ONE = 2'h1,
      DMC_WIN_OVL_TWO = 2'h2
   } dmc_window_t;

   typedef enum logic [1:0] {
      DMC_SRC_SPRITE = 2'h0,
      DMC_SRC_CAMERA = 2'h1
   } dmc_source_t;

   typedef enum logic [1:0] {
      DMC_DB_IDLE = 2'b00,
      DMC_DB_ARMED = 2'b01,
      DMC_DB_RUN = 2'b11
   } dmc_db_state_t;

endpackage
`default_nettype wire

// ### dmc_dbuf_swap.sv
/*
 Double buffer sequencer: arms on the enable bit with cfg_valid set, starts and stops at frame
 boundaries and swaps the front buffer once per frame while running.
 Assumes frame_start is a one-cycle pulse on pclk from the display timing.
*/
`timescale 1ns/100ps
`default_nettype none
module dmc_dbuf_swap (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic enable,
   input wire logic cfg_valid,
   input wire logic frame_start,
   // Status.
   output logic active,
   output logic front
);

   dmc_pkg::dmc_db_state_t state_reg, state_next;
   logic front_reg, front_next;

   always_comb begin
      state_next = state_reg;
      front_next = front_reg;
      unique case (state_reg)
         dmc_pkg::DMC_DB_IDLE: begin
            if (enable && cfg_valid) begin
               state_next = dmc_pkg::DMC_DB_ARMED;
            end
         end
         dmc_pkg::DMC_DB_ARMED: begin
            if (!(enable && cfg_valid)) begin
               state_next = dmc_pkg::DMC_DB_IDLE;
            end else if (frame_start) begin
               state_next = dmc_pkg::DMC_DB_RUN;
               front_next = 1'b0;
            end
         end
         dmc_pkg::DMC_DB_RUN: begin
            // Stopping waits for the boundary so the last frame stays whole.
            if (frame_start) begin
               if (enable && cfg_valid) begin
                  front_next = ~front_reg;
               end else begin
                  state_next = dmc_pkg::DMC_DB_IDLE;
                  front_next = 1'b0;
               end
            end
         end
         default: begin
            state_next = dmc_pkg::DMC_DB_IDLE;
            front_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= dmc_pkg::DMC_DB_IDLE;
         front_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         front_reg <= front_next;
      end
   end

   assign active = (state_reg == dmc_pkg::DMC_DB_RUN);
   assign front = front_reg;

   AST_SWAP_AT_BOUNDARY: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(front_reg) |-> $past(frame_start))
      else $error("Front buffer changed away from a frame boundary.");

   AST_SWAP_EACH_FRAME: assert property (
      @(posedge pclk) disable iff (!presetn)
      active && frame_start && enable && cfg_valid
      |=> active && (front_reg != $past(front_reg)))
      else $error("Running double buffer did not swap at frame start.");

   AST_START_ON_FRAME: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_reg == dmc_pkg::DMC_DB_ARMED) && enable && cfg_valid
      && frame_start |=> active && !front_reg)
      else $error("Armed double buffer did not start at frame start.");

   AST_STOP_ON_FRAME: assert property (
      @(posedge pclk) disable iff (!presetn)
      active && !enable && frame_start |=> !active ##1 !active)
      else $error("Disabled double buffer kept running past the boundary.");

endmodule
`default_nettype wire

// ### dmc_top.sv
/*
 Display mode configuration block: APB slave holding the depth select and
 the double buffer control registers, depth decode, colour limit and the
 double buffer sequencer.
 Assumes panel, pseudo colour, output select and frame_start come from
 logic on pclk, so none of them is synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmc_cfg.svh"
module dmc_top (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Settings of neighbouring blocks.
   input wire logic [2:0] panel_type,
   input wire logic pseudo_colour_on,
   input wire logic [2:0] output_select,
   input wire logic frame_start,
   // Depth results.
   output logic [2:0] main_depth,
   output logic [5:0] main_bpp,
   output logic depth_reserved,
   output logic yuv_depth_mismatch,
   output logic [24:0] colour_limit,
   // Double buffer results.
   output logic dbuf_active,
   output logic dbuf_front,
   output logic [1:0] dbuf_window,
   output logic [1:0] dbuf_source,
   output logic dbuf_cfg_reserved
);

   logic [15:0] depth_reg, depth_next;
   logic [15:0] dbuf_reg, dbuf_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [5:0] bpp_reg, bpp_next;
   logic [24:0] limit_reg, limit_next;
   logic hit_depth, hit_dbuf, setup, access;
   logic cfg_valid;

   assign hit_depth = (paddr == `DMC_ADDR_DEPTH);
   assign hit_dbuf = (paddr == `DMC_ADDR_DBUF);
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access && !(hit_depth || hit_dbuf);

   // Register group: writes land at the access edge, read data is caught
   // at the setup edge so prdata comes from a flop with no wait state.
   always_comb begin
      depth_next = depth_reg;
      dbuf_next = dbuf_reg;
      prdata_next = prdata_reg;
      if (access && pwrite && hit_depth) begin
         depth_next = pwdata[15:0] & `DMC_DEPTH_MASK;
      end
      if (access && pwrite && hit_dbuf) begin
         dbuf_next = pwdata[15:0] & `DMC_DBUF_MASK;
      end
      if (setup && !pwrite) begin
         if (hit_depth) begin
            prdata_next = {16'h0000, depth_reg};
         end else if (hit_dbuf) begin
            prdata_next = {16'h0000, dbuf_reg};
         end else begin
            prdata_next = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_reg <= `DMC_DEPTH_RESET;
         dbuf_reg <= `DMC_DBUF_RESET;
         prdata_reg <= 32'h0000_0000;
      end else begin
         depth_reg <= depth_next;
         dbuf_reg <= dbuf_next;
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;

   // Depth group. The depth register feeds the pipeline live; software is
   // expected to change it only during vertical non-display.
   always_comb begin
      bpp_next = `DMC_BPP_NONE;
      limit_next = `DMC_COLOURS_NONE;
      unique case (depth_reg[`DMC_MAIN_MSB:`DMC_MAIN_LSB])
         dmc_pkg::DMC_DEPTH_8: begin
            bpp_next = `DMC_BPP_8;
            limit_next = `DMC_COLOURS_8;
         end
         dmc_pkg::DMC_DEPTH_16, dmc_pkg::DMC_DEPTH_YUV: begin
            bpp_next = `DMC_BPP_16;
            limit_next = `DMC_COLOURS_16;
         end
         dmc_pkg::DMC_DEPTH_32: begin
            bpp_next = `DMC_BPP_32;
            limit_next = (pseudo_colour_on && panel_type == `DMC_PANEL_TYPE2)
               ? `DMC_COLOURS_18 : `DMC_COLOURS_24;
         end
         default: begin
            bpp_next = `DMC_BPP_NONE;
            limit_next = `DMC_COLOURS_NONE;
         end
      endcase
      if (pseudo_colour_on && panel_type == `DMC_PANEL_MONO
          && bpp_next != `DMC_BPP_NONE) begin
         limit_next = `DMC_COLOURS_GREY;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bpp_reg <= `DMC_BPP_8;
         limit_reg <= `DMC_COLOURS_8;
      end else begin
         bpp_reg <= bpp_next;
         limit_reg <= limit_next;
      end
   end

   assign main_depth = depth_reg[`DMC_MAIN_MSB:`DMC_MAIN_LSB];
   assign main_bpp = bpp_reg;
   assign colour_limit = limit_reg;
   assign depth_reserved = (bpp_reg == `DMC_BPP_NONE);
   // Flags a setting software must avoid; the pipeline still uses it.
   assign yuv_depth_mismatch = (output_select == `DMC_OUT_YUV)
      && (depth_reg[`DMC_MAIN_MSB:`DMC_MAIN_LSB] != dmc_pkg::DMC_DEPTH_YUV);

   // Double buffer group. Reserved window or source codes keep the
   // sequencer from starting rather than aiming at an undefined target.
   assign cfg_valid =
      (dbuf_reg[`DMC_DB_WIN_MSB:`DMC_DB_WIN_LSB] != 2'h3)
      && !dbuf_reg[`DMC_DB_SRC_MSB];
   assign dbuf_window = dbuf_reg[`DMC_DB_WIN_MSB:`DMC_DB_WIN_LSB];
   assign dbuf_source = dbuf_reg[`DMC_DB_SRC_MSB:`DMC_DB_SRC_LSB];
   assign dbuf_cfg_reserved = !cfg_valid;

   dmc_dbuf_swap u_swap (
      .pclk(pclk),
      .presetn(presetn),
      .enable(dbuf_reg[`DMC_DB_EN_BIT]),
      .cfg_valid(cfg_valid),
      .frame_start(frame_start),
      .active(dbuf_active),
      .front(dbuf_front)
   );

   AST_DBUF_RESET_ZERO: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> dbuf_reg == 16'h0000 && !dbuf_active)
      else $error("Double buffer control not zero after reset.");

   AST_DBUF_WRITE_READ: assert property (
      @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit_dbuf ##1 !psel ##1 setup && !pwrite && hit_dbuf
      |=> prdata == {16'h0000, $past(pwdata[15:0], 3) & 16'hff07})
      else $error("Double buffer register did not read back the write.");

   AST_DEPTH_32: assert property (
      @(posedge pclk) disable iff (!presetn)
      depth_reg[2:0] == 3'h3 |=> main_bpp == 6'h20)
      else $error("Depth code 011b did not give 32 bpp.");

   AST_DEPTH_RESERVED: assert property (
      @(posedge pclk) disable iff (!presetn)
      depth_reg[2] |=> depth_reserved && colour_limit == 25'h000_0000)
      else $error("Reserved depth code not flagged.");

   AST_LIMIT_TYPE2: assert property (
      @(posedge pclk) disable iff (!presetn)
      pseudo_colour_on && panel_type == 3'h2 && depth_reg[2:0] == 3'h3
      |=> colour_limit == 25'h004_0000)
      else $error("Type 2 pseudo colour limit at 32 bpp is wrong.");

   AST_LIMIT_MONO: assert property (
      @(posedge pclk) disable iff (!presetn)
      pseudo_colour_on && panel_type == 3'h0 && !depth_reg[2]
      |=> colour_limit == 25'h000_0040)
      else $error("Monochrome pseudo colour limit is not 64.");

   AST_RESERVED_BLOCKS: assert property (
      @(posedge pclk) disable iff (!presetn)
      dbuf_window == 2'h3 && !dbuf_active |=> !dbuf_active)
      else $error("Double buffer started on a reserved window code.");

   AST_SOURCE_RESERVED: assert property (
      @(posedge pclk) disable iff (!presetn)
      dbuf_source[1] |-> dbuf_cfg_reserved)
      else $error("Reserved source code not flagged.");

   AST_DEPTH_8: assert property (
      @(posedge pclk) disable iff (!presetn)
      depth_reg[2:0] == 3'h0 |=> main_bpp == 6'h08)
      else $error("Depth code 000b did not give 8 bpp.");

   AST_DEPTH_16: assert property (
      @(posedge pclk) disable iff (!presetn)
      depth_reg[2:0] == 3'h1 |=> main_bpp == 6'h10)
      else $error("Depth code 001b did not give 16 bpp.");

   AST_LIMIT_TYPE2_16: assert property (
      @(posedge pclk) disable iff (!presetn)
      pseudo_colour_on && panel_type == 3'h2 && depth_reg[2:0] == 3'h1
      |=> colour_limit == 25'h001_0000)
      else $error("Type 2 pseudo colour limit at 16 bpp is wrong.");

   AST_DEPTH_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      access && pwrite && hit_depth
      |=> depth_reg == ($past(pwdata[15:0]) & 16'h8f77))
      else $error("Depth register did not take the written value.");

   AST_UNMAPPED_NO_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      access && pwrite && !(hit_depth || hit_dbuf)
      |=> $stable(depth_reg) && $stable(dbuf_reg))
      else $error("Write to an unmapped address changed a register.");

endmodule
`default_nettype wire

// ### display_mode_config_tb.sv
/*
 Self-checking bench of dmc_top: register access over APB, depth decode,
 colour limits and the double buffer sequencer, with random data.
 Assumes dmc_pkg, dmc_dbuf_swap, dmc_top and dmc_cfg.svh are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dmc_cfg.svh"
module display_mode_config_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] panel_type = 3'h0;
   logic pseudo_colour_on = 1'b0;
   logic [2:0] output_select = 3'h0;
   logic frame_start = 1'b0;
   logic [2:0] main_depth;
   logic [5:0] main_bpp;
   logic depth_reserved;
   logic yuv_depth_mismatch;
   logic [24:0] colour_limit;
   logic dbuf_active;
   logic dbuf_front;
   logic [1:0] dbuf_window;
   logic [1:0] dbuf_source;
   logic dbuf_cfg_reserved;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] r;
   logic [31:0] d;
   logic e;
   logic [2:0] c;
   logic bad;

   dmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .panel_type(panel_type), .pseudo_colour_on(pseudo_colour_on),
      .output_select(output_select), .frame_start(frame_start),
      .main_depth(main_depth), .main_bpp(main_bpp),
      .depth_reserved(depth_reserved),
      .yuv_depth_mismatch(yuv_depth_mismatch),
      .colour_limit(colour_limit), .dbuf_active(dbuf_active),
      .dbuf_front(dbuf_front), .dbuf_window(dbuf_window),
      .dbuf_source(dbuf_source), .dbuf_cfg_reserved(dbuf_cfg_reserved));

   always #25 pclk = ~pclk;

   task automatic wrap_up();
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run for ever.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge pclk) begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
      end
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      // Only the bench timeout ends a wait that never sees pready.
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse();
      @(posedge pclk) frame_start <= 1'b1;
      @(posedge pclk) frame_start <= 1'b0;
      @(negedge pclk);
   endtask

   function automatic logic [5:0] exp_bpp(input logic [2:0] code);
      case (code)
         3'h0: return 6'h08;
         3'h1, 3'h2: return 6'h10;
         3'h3: return 6'h20;
         default: return 6'h00;
      endcase
   endfunction

   // Mode 0 is colour type 2 with pseudo colour, 1 mono with it, 2 plain.
   function automatic logic [24:0] exp_lim(input logic [2:0] code, int m);
      logic [5:0] b;
      b = exp_bpp(code);
      if (b == 6'h00) return 25'h000_0000;
      if (m == 1) return 25'h000_0040;
      if (m == 0 && b == 6'h20) return 25'h004_0000;
      if (b == 6'h08) return 25'h000_0100;
      if (b == 6'h10) return 25'h001_0000;
      return 25'h100_0000;
   endfunction

   initial begin
      d = $urandom(32'h3472a5f0);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `DMC_ADDR_DBUF, 32'h0000_0000, r, e);
      chk("dbuf_reg_reset", 32'h0000_0000, r);
      chk("bpp_reset", 32'h0000_0008, 32'(main_bpp));
      chk("pready", 32'h0000_0001, 32'(pready));
      apb(1'b0, 16'h0010, 32'h0000_0000, r, e);
      chk("unmapped_err", 32'h0000_0001, 32'(e));
      chk("unmapped_data", 32'h0000_0000, r);
      apb(1'b1, 16'h0010, 32'hffff_ffff, r, e);
      chk("unmapped_werr", 32'h0000_0001, 32'(e));
      apb(1'b0, `DMC_ADDR_DEPTH, 32'h0000_0000, r, e);
      chk("no_write", 32'h0000_0000, r);
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            d = $urandom();
            d[2:0] = c;
            @(posedge pclk) begin
               panel_type <= (m == 1) ? 3'h0 : 3'h2;
               pseudo_colour_on <= (m < 2);
               output_select <= ($urandom() % 2) ? 3'h4 : 3'($urandom());
            end
            // No frame starts here, as in vertical non-display.
            apb(1'b1, `DMC_ADDR_DEPTH, d, r, e);
            chk("mapped_err", 32'h0000_0000, 32'(e));
            apb(1'b0, `DMC_ADDR_DEPTH, 32'h0000_0000, r, e);
            chk("depth_reg", d & 32'h0000_8f77, r);
            chk("main_depth", 32'(c), 32'(main_depth));
            chk("main_bpp", 32'(exp_bpp(c)), 32'(main_bpp));
            chk("reserved", 32'(exp_bpp(c) == 0), 32'(depth_reserved));
            chk("limit", 32'(exp_lim(c, m)), 32'(colour_limit));
            bad = (output_select == 3'h4) && (c != 3'h2);
            chk("yuv_flag", 32'(bad), 32'(yuv_depth_mismatch));
         end
      end
      apb(1'b1, `DMC_ADDR_DBUF, 32'h0000_2800, r, e);
      apb(1'b1, `DMC_ADDR_DBUF, 32'h0000_a800, r, e);
      repeat (4) @(negedge pclk);
      chk("armed_idle", 32'h0000_0000, 32'(dbuf_active));
      pulse();
      chk("run_active", 32'h0000_0001, 32'(dbuf_active));
      chk("run_front", 32'h0000_0000, 32'(dbuf_front));
      repeat (3) @(negedge pclk);
      chk("front_hold", 32'h0000_0000, 32'(dbuf_front));
      pulse();
      chk("front_swap", 32'h0000_0001, 32'(dbuf_front));
      pulse();
      chk("front_back", 32'h0000_0000, 32'(dbuf_front));
      apb(1'b1, `DMC_ADDR_DBUF, 32'h0000_2800, r, e);
      @(negedge pclk);
      chk("stop_wait", 32'h0000_0001, 32'(dbuf_active));
      pulse();
      chk("stopped", 32'h0000_0000, 32'(dbuf_active));
      for (int k = 0; k < 16; k++) begin
         d = {16'h0000, 1'b1, 2'(k / 4), 2'(k % 4), 11'($urandom())};
         // The camera write engine lies outside this block and is taken
         // as set up for double buffering whenever it is the source.
         apb(1'b1, `DMC_ADDR_DBUF, d & 32'h0000_7fff, r, e);
         apb(1'b1, `DMC_ADDR_DBUF, d, r, e);
         apb(1'b0, `DMC_ADDR_DBUF, 32'h0000_0000, r, e);
         chk("dbuf_reg", d & 32'h0000_ff07, r);
         bad = (k / 4 == 3) || (k % 4 >= 2);
         pulse();
         chk("window", 32'(k / 4), 32'(dbuf_window));
         chk("source", 32'(k % 4), 32'(dbuf_source));
         chk("cfg_res", 32'(bad), 32'(dbuf_cfg_reserved));
         chk("active", 32'(!bad), 32'(dbuf_active));
         apb(1'b1, `DMC_ADDR_DBUF, 32'h0000_0000, r, e);
         pulse();
         chk("off", 32'h0000_0000, 32'(dbuf_active));
      end
      // A reset in mid-run must clear a running double buffer.
      apb(1'b1, `DMC_ADDR_DBUF, 32'h0000_0000, r, e);
      apb(1'b1, `DMC_ADDR_DBUF, 32'h0000_8000, r, e);
      pulse();
      chk("rerun", 32'h0000_0001, 32'(dbuf_active));
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `DMC_ADDR_DBUF, 32'h0000_0000, r, e);
      chk("dbuf_reg_rst2", 32'h0000_0000, r);
      chk("active_rst2", 32'h0000_0000, 32'(dbuf_active));
      apb(1'b0, `DMC_ADDR_DEPTH, 32'h0000_0000, r, e);
      chk("depth_rst2", 32'h0000_0000, r);
      chk("bpp_rst2", 32'h0000_0008, 32'(main_bpp));
      wrap_up();
   end
endmodule
`default_nettype wire
